// ### core/artp_pkg.sv
// Package of register map, field layout and constants for the reload timer
package artp_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ARTP_OFF_MODE   = 8'hb8;
    localparam logic [7:0] ARTP_OFF_COUNT  = 8'hb9;
    localparam logic [7:0] ARTP_OFF_RELOAD = 8'hba;
    localparam logic [7:0] ARTP_OFF_DUTY   = 8'hbb;
    localparam logic [7:0] ARTP_OFF_STAT   = 8'hbf;

    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int ARTP_MODE_PWM_EN_BIT  = 0;
    localparam int ARTP_MODE_OSC_SEL_BIT = 2;
    localparam int ARTP_MODE_EXT_SEL_BIT = 3;
    localparam int ARTP_MODE_RATE_LSB    = 4;
    localparam int ARTP_MODE_RUN_BIT     = 7;
    localparam logic [7:0] ARTP_MODE_WR_MASK = 8'hfd;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int ARTP_STAT_OVF_BIT  = 0;
    localparam int ARTP_STAT_IEN_BIT  = 1;
    localparam int ARTP_STAT_PINF_BIT = 2;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] ARTP_RST_MODE   = 8'h00;
    localparam logic [7:0] ARTP_RST_COUNT  = 8'h00;
    localparam logic [7:0] ARTP_RST_RELOAD = 8'h00;
    localparam logic [7:0] ARTP_RST_DUTY   = 8'h00;
    localparam logic [7:0] ARTP_FULL_SCALE = 8'hff;
    localparam int         ARTP_MAX_DIV    = 128;
    localparam int         ARTP_DIV_BITS   = 7;

    typedef enum logic {
        ARTP_SRC_CPU,
        ARTP_SRC_OSC
    } artp_src_t;

endpackage

// ### core/artp_prescaler.sv
// Power-of-two prescaler for the internal timer clock
`timescale 1ns/10ps
module artp_prescaler
    import artp_pkg::*;
#(
    parameter int DIV_BITS = ARTP_DIV_BITS
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Source and rate
    input  wire logic       i_src_tick,
    input  wire logic [2:0] i_rate,
    // Divided tick
    output logic            o_tick
);

    logic [DIV_BITS-1:0] cnt_q;
    logic [DIV_BITS-1:0] cnt_d;
    logic [DIV_BITS-1:0] mask;

    // ------------------------------------------------------------
    // Mask of low bits that must be all ones
    // ------------------------------------------------------------
    assign mask   = {DIV_BITS{1'b1}} >> i_rate; // (R22)
    assign cnt_d  = i_src_tick ? cnt_q + 1'b1 : cnt_q;
    assign o_tick = i_src_tick && ((cnt_q & mask) == mask); // (R22)

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule // artp_prescaler

// ### core/artp_timer.sv
// Eight-bit auto-reload timer, event counter and PWM generator
//
// Operation
// (R1) Eight-bit up counter sets a sticky overflow flag that software clears.
// (R2) Software loads count and reload with one value before first enable.
// (R3) Each overflow reloads the counter automatically from the reload value.
// (R4) Reload writes go to a buffer, made active at the next overflow.
// (R5) Software changes the interval through reload, not the count, while running.
// (R6) Start value is 256 minus interval times timer clock rate.
// (R7) Counter equal to duty ends the PWM high phase.
// (R8) Duty is reload plus high width over timer clock period.
// (R9) External select counts falling edges of the event input pin.
// (R10) Overflow happens exactly on the wrap from full scale to zero.
// (R11) Event counting disables wake-up from the event input pin.
// (R12) Event counting disables the pin interrupt and holds its flag at zero.
// (R13) Running with PWM enabled drives the waveform onto the shared pin.
// (R14) Each PWM period is high first, then low.
// (R15) Each overflow ends the period and drives the output high again.
// (R16) Period changes while running take effect at the next reload.
// (R17) Resolution follows reload: zero gives 256 steps, 0x80 gives 128.
// (R18) Duty not above reload keeps the output low all period.
// (R19) PWM still sets the overflow flag and requests with enable set.
// (R20) Clearing PWM enable returns the pin to its port setting.
// (R21) Counter holds with run clear and counts on the timer clock when set.
// (R22) Prescale code 000 divides by 128, halving per step to 1.
// (R23) Event input is synchronised before falling edges are detected.
// (R24) Reset clears counter, reload buffers and duty; PWM inactive.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
module artp_timer
    import artp_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Register port
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // Instruction clock tick
    input  wire logic       i_cpu_tick,
    // Event input pin and its port functions
    input  wire logic       i_event_input_pin,
    input  wire logic       i_pin_wake_enable,
    input  wire logic       i_pin_irq_enable,
    output logic            o_pin_wake_enable,
    output logic            o_pin_irq,
    // Shared PWM output pin
    input  wire logic       i_port_out,
    input  wire logic       i_port_oe,
    output logic            o_pwm_output_pin,
    output logic            o_pwm_output_pin_oe,
    // Overflow request
    output logic            o_overflow_irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] rld_buf_q;
    logic [7:0] rld_buf_d;
    logic [7:0] rld_act_q;
    logic [7:0] rld_act_d;
    logic [7:0] duty_q;
    logic [7:0] duty_d;
    logic       ovf_flag_q;
    logic       ovf_flag_d;
    logic       ovf_ien_q;
    logic       ovf_ien_d;
    logic       pin_flag_q;
    logic       pin_flag_d;
    logic       pwm_q;
    logic       pwm_d;
    logic       run_prev_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       sync1_q;
    logic       sync2_q;
    logic       sync3_q;

    logic       run;
    logic       pwm_en;
    logic       ext_sel;
    logic [2:0] rate;
    artp_src_t  src;
    logic       src_tick;
    logic       pre_tick;
    logic       ev_fall;
    logic       cnt_tick;
    logic       ovf_evt;
    logic       run_rise;
    logic       sel_mode;
    logic       sel_cnt;
    logic       sel_rld;
    logic       sel_duty;
    logic       sel_stat;
    logic       wr_mode;
    logic       wr_cnt;
    logic       wr_rld;
    logic       wr_duty;
    logic       wr_stat;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign sel_mode = (i_addr == ARTP_OFF_MODE);
    assign sel_cnt  = (i_addr == ARTP_OFF_COUNT);
    assign sel_rld  = (i_addr == ARTP_OFF_RELOAD);
    assign sel_duty = (i_addr == ARTP_OFF_DUTY);
    assign sel_stat = (i_addr == ARTP_OFF_STAT);
    assign wr_mode  = i_wr && sel_mode;
    assign wr_cnt   = i_wr && sel_cnt;
    assign wr_rld   = i_wr && sel_rld;
    assign wr_duty  = i_wr && sel_duty;
    assign wr_stat  = i_wr && sel_stat;

    // ------------------------------------------------------------
    // Mode fields
    // ------------------------------------------------------------
    assign run     = mode_q[ARTP_MODE_RUN_BIT];
    assign pwm_en  = mode_q[ARTP_MODE_PWM_EN_BIT];
    assign ext_sel = mode_q[ARTP_MODE_EXT_SEL_BIT];
    assign rate    = mode_q[ARTP_MODE_RATE_LSB +: 3];
    assign src     = mode_q[ARTP_MODE_OSC_SEL_BIT] ? ARTP_SRC_OSC : ARTP_SRC_CPU;
    assign mode_d  = wr_mode ? (i_wdata & ARTP_MODE_WR_MASK) : mode_q;

    // ------------------------------------------------------------
    // Timer clock selection
    // ------------------------------------------------------------
    assign src_tick = (src == ARTP_SRC_OSC) ? 1'b1 : i_cpu_tick;

    artp_prescaler #(
        .DIV_BITS (ARTP_DIV_BITS)
    ) artp_prescaler_inst (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_src_tick (src_tick),
        .i_rate     (rate),
        .o_tick     (pre_tick)
    );

    assign ev_fall  = sync3_q && !sync2_q; // (R23)
    assign cnt_tick = run && (ext_sel ? ev_fall : pre_tick); // (R9) (R21)
    assign ovf_evt  = cnt_tick && (cnt_q == ARTP_FULL_SCALE) && !wr_cnt; // (R10)
    assign run_rise = run && !run_prev_q;

    // ------------------------------------------------------------
    // Counter and reload
    // ------------------------------------------------------------
    assign cnt_d = wr_cnt   ? i_wdata :
                   ovf_evt  ? rld_buf_q : // (R3) (R17)
                   cnt_tick ? cnt_q + 8'h01 : cnt_q; // (R21)

    assign rld_buf_d = wr_rld ? i_wdata : rld_buf_q; // (R4)
    assign rld_act_d = ovf_evt          ? rld_buf_q : // (R4) (R16)
                       (wr_rld && !run) ? i_wdata : rld_act_q;
    assign duty_d    = wr_duty ? i_wdata : duty_q;

    // ------------------------------------------------------------
    // Flags, set wins over clear
    // ------------------------------------------------------------
    assign ovf_flag_d = ovf_evt ? 1'b1 : // (R1) (R19)
                        (wr_stat && !i_wdata[ARTP_STAT_OVF_BIT]) ? 1'b0 : ovf_flag_q;
    assign ovf_ien_d  = wr_stat ? i_wdata[ARTP_STAT_IEN_BIT] : ovf_ien_q;
    assign pin_flag_d = ext_sel ? 1'b0 : // (R12)
                        (ev_fall && i_pin_irq_enable) ? 1'b1 :
                        (wr_stat && !i_wdata[ARTP_STAT_PINF_BIT]) ? 1'b0 : pin_flag_q;

    // ------------------------------------------------------------
    // PWM waveform
    // ------------------------------------------------------------
    always_comb begin
        pwm_d = pwm_q;
        if (!run) begin
            pwm_d = 1'b0;
        end else if (ovf_evt) begin
            pwm_d = (duty_q > rld_buf_q); // (R15) (R18)
        end else if (run_rise) begin
            pwm_d = (duty_q > cnt_q); // (R14)
        end else if (cnt_q == duty_q) begin
            pwm_d = 1'b0; // (R7)
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        if (!i_rd) begin
            rdata_d = 8'h00;
        end else if (sel_mode) begin
            rdata_d = mode_q;
        end else if (sel_cnt) begin
            rdata_d = cnt_q;
        end else if (sel_duty) begin
            rdata_d = duty_q;
        end else if (sel_stat) begin
            rdata_d = {5'h00, pin_flag_q, ovf_ien_q, ovf_flag_q};
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_q     <= ARTP_RST_MODE;
            cnt_q      <= ARTP_RST_COUNT; // (R24)
            rld_buf_q  <= ARTP_RST_RELOAD;
            rld_act_q  <= ARTP_RST_RELOAD;
            duty_q     <= ARTP_RST_DUTY;
            ovf_flag_q <= 1'b0;
            ovf_ien_q  <= 1'b0;
            pin_flag_q <= 1'b0;
            pwm_q      <= 1'b0;
            run_prev_q <= 1'b0;
            rdata_q    <= 8'h00;
        end else begin
            mode_q     <= mode_d;
            cnt_q      <= cnt_d;
            rld_buf_q  <= rld_buf_d;
            rld_act_q  <= rld_act_d;
            duty_q     <= duty_d;
            ovf_flag_q <= ovf_flag_d;
            ovf_ien_q  <= ovf_ien_d;
            pin_flag_q <= pin_flag_d;
            pwm_q      <= pwm_d;
            run_prev_q <= run;
            rdata_q    <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Event input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            sync3_q <= 1'b1;
        end else begin
            sync1_q <= i_event_input_pin; // (R23)
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata             = rdata_q;
    assign o_overflow_irq      = ovf_flag_q && ovf_ien_q; // (R19)
    assign o_pin_wake_enable   = i_pin_wake_enable && !ext_sel; // (R11)
    assign o_pin_irq           = pin_flag_q; // (R12)
    assign o_pwm_output_pin    = (run && pwm_en) ? pwm_q : i_port_out; // (R13) (R20)
    assign o_pwm_output_pin_oe = (run && pwm_en) ? 1'b1 : i_port_oe; // (R13) (R20)

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    chk_ovf_flag_set: assert property ( // (R1)
        ovf_evt |=> ovf_flag_q)
        else $error("overflow flag not set after overflow");

    chk_ovf_flag_hold: assert property ( // (R1)
        ovf_flag_q && !wr_stat |=> ovf_flag_q)
        else $error("overflow flag dropped without a clear");

    chk_reload_load: assert property ( // (R3)
        ovf_evt |=> cnt_q == $past(rld_buf_q))
        else $error("counter not reloaded on overflow");

    chk_reload_move: assert property ( // (R4)
        run && wr_rld && !ovf_evt ##1 !ovf_evt [*2]
        |-> rld_act_q == $past(rld_act_q, 2))
        else $error("reload buffer moved before overflow");

    chk_duty_match: assert property ( // (R7)
        run && run_prev_q && !ovf_evt && cnt_q == duty_q |=> !pwm_q)
        else $error("pwm not low at duty match");

    chk_event_count: assert property ( // (R9)
        run && ext_sel && ev_fall && cnt_q != ARTP_FULL_SCALE && !wr_cnt
        |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("event edge not counted");

    chk_wrap_only: assert property ( // (R10)
        $rose(ovf_flag_q) |-> $past(cnt_q) == ARTP_FULL_SCALE && $past(cnt_tick))
        else $error("overflow flag raised without full-scale wrap");

    chk_pin_flag_zero: assert property ( // (R12)
        ext_sel |=> !o_pin_irq)
        else $error("pin flag set during event counting");

    chk_pwm_restart: assert property ( // (R15)
        ovf_evt && duty_q > rld_buf_q |=> pwm_q)
        else $error("pwm not restarted high at overflow");

    chk_pwm_low_all: assert property ( // (R18)
        ovf_evt && duty_q <= rld_buf_q |=> !pwm_q)
        else $error("pwm high with duty not above reload");

    chk_count_hold: assert property ( // (R21)
        !run && !wr_cnt |=> $stable(cnt_q))
        else $error("counter moved while stopped");

    chk_pin_return: assert property ( // (R20)
        !pwm_en |-> o_pwm_output_pin == i_port_out && o_pwm_output_pin_oe == i_port_oe)
        else $error("pin not returned to port setting");

    chk_pwm_pin_drive: assert property ( // (R13)
        run && pwm_en |-> o_pwm_output_pin == pwm_q && o_pwm_output_pin_oe)
        else $error("pwm waveform not driven onto the pin");

    chk_stop_low: assert property ( // (R13)
        !run |=> !pwm_q)
        else $error("pwm high while timer stopped");

    chk_wake_block: assert property ( // (R11)
        ext_sel |-> !o_pin_wake_enable)
        else $error("wake-up left enabled during event counting");

    chk_irq_request: assert property ( // (R19)
        ovf_evt && ovf_ien_q && !wr_stat |=> o_overflow_irq)
        else $error("no overflow request with enable set");

    chk_reload_active: assert property ( // (R4)
        ovf_evt |=> rld_act_q == $past(rld_buf_q))
        else $error("buffered reload not made active at overflow");

    chk_sync_edge: assert property ( // (R23)
        ev_fall |-> $past(i_event_input_pin, 3) && !$past(i_event_input_pin, 2))
        else $error("event edge not taken from synchronised samples");

endmodule // artp_timer

// ### verif/artp_pulse_load.sv
// Partner model: external event pulse source and PWM-driven load
`timescale 1ns/10ps
module artp_pulse_load (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Pulse request
    input  wire logic        i_start,
    input  wire logic [7:0]  i_edges,
    output logic             o_busy,
    output logic             o_pin,
    // Load side
    input  wire logic        i_load_pin,
    input  wire logic        i_load_oe,
    output logic      [15:0] o_rises
);
    logic [7:0] left_q;
    logic [2:0] ph_q;
    logic       load_q;

    assign o_busy = (left_q != 8'h00);

    // ------------------------------------------------------------
    // Pulse train, pin pulled high when idle
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            left_q <= 8'h00;
            ph_q   <= 3'h0;
            o_pin  <= 1'b1;
        end else if (i_start) begin
            left_q <= i_edges;
            ph_q   <= 3'h0;
        end else if (o_busy) begin
            ph_q <= ph_q + 3'h1;
            if (ph_q == 3'h3) begin
                o_pin <= 1'b0;
            end
            if (ph_q == 3'h7) begin
                o_pin  <= 1'b1;
                left_q <= left_q - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Load counts rising edges while the pin is driven
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            load_q  <= 1'b0;
            o_rises <= 16'h0000;
        end else begin
            load_q <= i_load_pin & i_load_oe;
            if (i_load_pin && i_load_oe && !load_q) begin
                o_rises <= o_rises + 16'h0001;
            end
        end
    end
endmodule // artp_pulse_load

// ### verif/artp_timer_tb_top.sv
// Testbench for the reload timer, event counter and PWM output
`timescale 1ns/10ps
module artp_timer_tb_top
    import artp_pkg::*;
;
    localparam logic [7:0] M_RUN = 8'h01 << ARTP_MODE_RUN_BIT;
    localparam logic [7:0] M_PWM = 8'h01 << ARTP_MODE_PWM_EN_BIT;
    localparam logic [7:0] M_EXT = 8'h01 << ARTP_MODE_EXT_SEL_BIT;
    localparam logic [7:0] M_OSC = 8'h01 << ARTP_MODE_OSC_SEL_BIT;
    localparam logic [7:0] M_R7  = 8'h07 << ARTP_MODE_RATE_LSB;

    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_cpu_tick = 1'b0;
    logic        i_pin_wake_enable = 1'b1;
    logic        i_pin_irq_enable = 1'b1;
    logic        i_port_out = 1'b0;
    logic        i_port_oe = 1'b0;
    logic        p_start = 1'b0;
    logic [7:0]  p_edges = 8'h00;
    logic        p_busy;
    logic        ev_pin;
    logic [15:0] rises;
    logic [15:0] r0;
    logic [7:0]  o_rdata;
    logic        o_pin_wake_enable;
    logic        o_pin_irq;
    logic        o_pwm_output_pin;
    logic        o_pwm_output_pin_oe;
    logic        o_overflow_irq;
    logic [7:0]  expv;
    int          n_fail = 0;
    int          num_checks = 0;
    logic [7:0]  addrs [6] = '{ARTP_OFF_MODE, ARTP_OFF_COUNT, ARTP_OFF_RELOAD,
                               ARTP_OFF_DUTY, ARTP_OFF_STAT, 8'hc0};

    always #10 i_clk = ~i_clk;

    artp_timer artp_timer_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_cpu_tick(i_cpu_tick), .i_event_input_pin(ev_pin),
        .i_pin_wake_enable(i_pin_wake_enable), .i_pin_irq_enable(i_pin_irq_enable),
        .o_pin_wake_enable(o_pin_wake_enable), .o_pin_irq(o_pin_irq),
        .i_port_out(i_port_out), .i_port_oe(i_port_oe),
        .o_pwm_output_pin(o_pwm_output_pin), .o_pwm_output_pin_oe(o_pwm_output_pin_oe),
        .o_overflow_irq(o_overflow_irq));

    artp_pulse_load artp_pulse_load_inst (.i_clk(i_clk), .i_rst(i_rst),
        .i_start(p_start), .i_edges(p_edges), .o_busy(p_busy), .o_pin(ev_pin),
        .i_load_pin(o_pwm_output_pin), .i_load_oe(o_pwm_output_pin_oe), .o_rises(rises));

    // ------------------------------------------------------------
    // Bus, tick and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, e);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge i_clk);
            i_cpu_tick <= 1'b1;
            @(posedge i_clk);
            i_cpu_tick <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
    endtask

    task automatic pulses(input logic [7:0] n);
        @(posedge i_clk);
        p_start <= 1'b1;
        p_edges <= n;
        @(posedge i_clk);
        p_start <= 1'b0;
        #1;
        for (int k = 0; k < 400 && p_busy; k++) @(posedge i_clk);
        repeat (6) @(posedge i_clk);
        chk({7'h00, p_busy}, 8'h00);
    endtask

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        n_fail++;
        complete_run;
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (addrs[i]) rdchk(addrs[i], 8'h00);
        chk({7'h00, o_pwm_output_pin_oe}, 8'h00);
        wr(8'hc0, 8'h55);
        rdchk(8'hc0, 8'h00);
        // Prescale codes, two counts each
        wr(ARTP_OFF_COUNT, 8'h10);
        wr(ARTP_OFF_RELOAD, 8'h10);
        expv = 8'h10;
        for (int c = 0; c < 8; c++) begin
            wr(ARTP_OFF_MODE, M_RUN | (8'(c) << ARTP_MODE_RATE_LSB));
            tick(2 * (ARTP_MAX_DIV >> c));
            expv = expv + 8'h02;
            rdchk(ARTP_OFF_COUNT, expv);
        end
        wr(ARTP_OFF_MODE, M_R7);
        tick(5);
        rdchk(ARTP_OFF_COUNT, expv);
        // Exact wrap for both resolutions
        for (int j = 0; j < 2; j++) begin
            expv = (j == 0) ? 8'h00 : 8'h80;
            wr(ARTP_OFF_MODE, 8'h00);
            wr(ARTP_OFF_COUNT, expv);
            wr(ARTP_OFF_RELOAD, expv);
            wr(ARTP_OFF_STAT, 8'h02);
            wr(ARTP_OFF_MODE, M_RUN | M_R7);
            tick(255 - int'(expv));
            rdchk(ARTP_OFF_STAT, 8'h02);
            chk({7'h00, o_overflow_irq}, 8'h00);
            tick(1);
            rdchk(ARTP_OFF_COUNT, expv);
            rdchk(ARTP_OFF_STAT, 8'h03);
            chk({7'h00, o_overflow_irq}, 8'h01);
            wr(ARTP_OFF_STAT, 8'h03);
            rdchk(ARTP_OFF_STAT, 8'h03);
            wr(ARTP_OFF_STAT, 8'h02);
            rdchk(ARTP_OFF_STAT, 8'h02);
        end
        // Reload buffered until overflow
        wr(ARTP_OFF_MODE, 8'h00);
        wr(ARTP_OFF_COUNT, 8'hfe);
        wr(ARTP_OFF_RELOAD, 8'hfe);
        wr(ARTP_OFF_MODE, M_RUN | M_R7);
        wr(ARTP_OFF_RELOAD, 8'h40);
        rdchk(ARTP_OFF_COUNT, 8'hfe);
        tick(1);
        rdchk(ARTP_OFF_COUNT, 8'hff);
        tick(1);
        rdchk(ARTP_OFF_COUNT, 8'h40);
        // PWM waveform on the shared pin
        wr(ARTP_OFF_MODE, 8'h00);
        i_port_oe <= 1'b1;
        wr(ARTP_OFF_COUNT, 8'hf0);
        wr(ARTP_OFF_RELOAD, 8'hf0);
        wr(ARTP_OFF_DUTY, 8'hf4);
        r0 = rises;
        wr(ARTP_OFF_MODE, M_RUN | M_R7 | M_PWM);
        tick(3);
        chk({6'h00, o_pwm_output_pin_oe, o_pwm_output_pin}, 8'h03);
        tick(1);
        chk({7'h00, o_pwm_output_pin}, 8'h00);
        tick(11);
        chk({7'h00, o_pwm_output_pin}, 8'h00);
        tick(1);
        chk({7'h00, o_pwm_output_pin}, 8'h01);
        chk(8'(rises - r0), 8'h02);
        wr(ARTP_OFF_DUTY, 8'hf0);
        tick(20);
        chk({7'h00, o_pwm_output_pin}, 8'h00);
        chk(8'(rises - r0), 8'h02);
        rdchk(ARTP_OFF_STAT, 8'h03);
        wr(ARTP_OFF_MODE, M_RUN | M_R7);
        i_port_out <= 1'b1;
        tick(1);
        chk({6'h00, o_pwm_output_pin_oe, o_pwm_output_pin}, 8'h03);
        rdchk(ARTP_OFF_COUNT, 8'hf5);
        // Event counting on falling edges
        wr(ARTP_OFF_MODE, 8'h00);
        wr(ARTP_OFF_COUNT, 8'hfe);
        wr(ARTP_OFF_RELOAD, 8'hfe);
        wr(ARTP_OFF_STAT, 8'h02);
        wr(ARTP_OFF_MODE, M_RUN | M_EXT);
        #1;
        chk({7'h00, o_pin_wake_enable}, 8'h00);
        pulses(8'h03);
        rdchk(ARTP_OFF_COUNT, 8'hff);
        rdchk(ARTP_OFF_STAT, 8'h03);
        chk({7'h00, o_pin_irq}, 8'h00);
        wr(ARTP_OFF_MODE, M_RUN);
        #1;
        chk({7'h00, o_pin_wake_enable}, 8'h01);
        pulses(8'h01);
        rdchk(ARTP_OFF_STAT, 8'h07);
        rdchk(ARTP_OFF_COUNT, 8'hff);
        // Oscillator source counts every clock
        wr(ARTP_OFF_COUNT, 8'h00);
        wr(ARTP_OFF_MODE, M_RUN | M_OSC | M_R7);
        wr(ARTP_OFF_MODE, 8'h00);
        rdchk(ARTP_OFF_COUNT, 8'h02);
        // Reset with the timer stopped
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (addrs[i]) rdchk(addrs[i], 8'h00);
        complete_run;
    end
endmodule // artp_timer_tb_top
